// ---- bt_if.sv ----
// Carrier between the transmit scheduler and the bit timer
`timescale 1ns/1ps
interface bt_if;
	logic [5:0] presc;
	logic [1:0] jump;
	logic [2:0] prop;
	logic [2:0] ph1;
	logic [2:0] ph2;
	logic       ph2_free;
	logic       triple_sample_select;
	logic       idle;
	logic       bit_start;
	logic       sample;
	logic       rx_bit;
	modport timer (input presc, jump, prop, ph1, ph2, ph2_free, triple_sample_select, idle,
		output bit_start, sample, rx_bit);
	modport ctrl (output presc, jump, prop, ph1, ph2, ph2_free, triple_sample_select, idle,
		input bit_start, sample, rx_bit);
endinterface : bt_if

// ---- can_bit_timer.sv ----
// Bit timer: quantum prescaler, segment sequencer, sync and sampling
`timescale 1ns/1ps
module can_bit_timer (
	// Clock, reset, enable
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic ce,
	// Module clock tick and bus level
	input  wire logic mclk_tick,
	input  wire logic rx,
	// Scheduler side
	bt_if.timer       bt
);
	import can_tx_pkg::*;
	logic [6:0] pre_ff;
	seg_t       seg_ff;
	logic [4:0] q_ff;
	logic [4:0] pos_ff;
	logic [3:0] adj_ff;
	logic [3:0] cut_ff;
	logic       rx_prev_ff;
	logic       synced_ff;
	logic [1:0] hist_ff;
	logic       tq;
	logic       half;
	logic       fall;
	logic       hard;
	logic       resync;
	logic       maj;
	logic [3:0] sjwq;
	logic [3:0] ph1q;
	logic [3:0] ph2q;
	logic [4:0] seg_len;
	logic [4:0] rem;
	assign tq   = mclk_tick && pre_ff == {bt.presc, 1'b1};
	assign half = mclk_tick && pre_ff == {1'b0, bt.presc};
	assign fall = rx_prev_ff && !rx;
	assign hard = fall && bt.idle;
	assign resync = fall && !bt.idle && !synced_ff && seg_ff != SEG_SYNC;
	assign maj  = (hist_ff[1] & hist_ff[0]) | (hist_ff[1] & rx) | (hist_ff[0] & rx);
	assign sjwq = {2'h0, bt.jump} + 4'h1;
	assign ph1q = {1'h0, bt.ph1} + 4'h1;
	assign rem  = seg_len - q_ff;
	always_comb begin
		ph2q = bt.ph2_free ? {1'h0, bt.ph2} + 4'h1 : ((ph1q > PH2_PROC) ? ph1q : PH2_PROC);
		case (seg_ff)
			SEG_SYNC: seg_len = 5'h01;
			SEG_PROP: seg_len = {2'h0, bt.prop} + 5'h01;
			SEG_PH1:  seg_len = {1'h0, ph1q} + {1'h0, adj_ff};
			SEG_PH2:  seg_len = {1'h0, ph2q} - {1'h0, cut_ff};
			default:  seg_len = 5'h01;
		endcase
	end
	// -----------------------------------------------
	// Prescaler and sample history
	// -----------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pre_ff     <= 7'h00;
			hist_ff    <= 2'h3;
			rx_prev_ff <= 1'b1;
		end else if (ce) begin
			rx_prev_ff <= rx;
			if (hard)
				pre_ff <= 7'h00;
			else if (mclk_tick)
				pre_ff <= tq ? 7'h00 : pre_ff + 7'h01;
			if (tq || half)
				hist_ff <= {hist_ff[0], rx};
		end
	end
	// -----------------------------------------------
	// Segment sequencer
	// -----------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			seg_ff       <= SEG_SYNC;
			q_ff         <= 5'h00;
			pos_ff       <= 5'h00;
			adj_ff       <= 4'h0;
			cut_ff       <= 4'h0;
			synced_ff    <= 1'b0;
			bt.bit_start <= 1'b0;
			bt.sample    <= 1'b0;
			bt.rx_bit    <= 1'b1;
		end else if (ce) begin
			bt.bit_start <= 1'b0;
			bt.sample    <= 1'b0;
			if (hard) begin
				seg_ff    <= SEG_SYNC;
				q_ff      <= 5'h00;
				pos_ff    <= 5'h00;
				adj_ff    <= 4'h0;
				cut_ff    <= 4'h0;
				synced_ff <= 1'b1;
			end else if (resync && seg_ff != SEG_PH2) begin
				adj_ff    <= ({1'h0, sjwq} < pos_ff) ? sjwq : pos_ff[3:0];
				synced_ff <= 1'b1;
			end else if (resync) begin
				synced_ff <= 1'b1;
				if (rem <= {1'h0, sjwq}) begin
					seg_ff       <= SEG_SYNC;
					q_ff         <= 5'h00;
					pos_ff       <= 5'h00;
					adj_ff       <= 4'h0;
					cut_ff       <= 4'h0;
					bt.bit_start <= 1'b1;
				end else
					cut_ff <= sjwq;
			end else if (tq) begin
				pos_ff <= pos_ff + 5'h01;
				if (q_ff + 5'h01 >= seg_len) begin
					q_ff <= 5'h00;
					case (seg_ff)
						SEG_SYNC: seg_ff <= SEG_PROP;
						SEG_PROP: seg_ff <= SEG_PH1;
						SEG_PH1: begin
							seg_ff    <= SEG_PH2;
							bt.sample <= 1'b1;
							bt.rx_bit <= bt.triple_sample_select ? maj : rx;
						end
						SEG_PH2: begin
							seg_ff       <= SEG_SYNC;
							pos_ff       <= 5'h00;
							adj_ff       <= 4'h0;
							cut_ff       <= 4'h0;
							synced_ff    <= 1'b0;
							bt.bit_start <= 1'b1;
						end
						default: seg_ff <= SEG_SYNC;
					endcase
				end else
					q_ff <= q_ff + 5'h01;
			end
		end
	end
endmodule : can_bit_timer

// ---- can_node.sv ----
// Far node: acknowledges and jams the bus
`timescale 1ns/1ps
module can_node #(parameter int BIT = 16) (
	input wire logic clk, can_tx, ack_en, jam,
	output logic can_rx
);
	int n = -1;
	always_ff @(posedge clk) n <= n < 0 ? (can_tx === 1'b0 ? 1 : -1) : n > 20 * BIT ? -1 : n + 1;
	assign can_rx = can_tx && !jam && !(ack_en && n > 12 * BIT && n < 13 * BIT - 2);
endmodule : can_node

// ---- can_tx_pkg.sv ----
// Constants and types for the CAN transmit scheduler and bit timer
package can_tx_pkg;
	localparam int NBUF = 8;
	localparam int AW   = 12;
	localparam int DW   = 32;
	// -----------------------------------------------
	// Register offsets
	// -----------------------------------------------
	localparam logic [AW-1:0] OFF_CTRL  = 12'h000;
	localparam logic [AW-1:0] OFF_CFG1  = 12'h004;
	localparam logic [AW-1:0] OFF_CFG2  = 12'h008;
	localparam logic [AW-1:0] OFF_INTF  = 12'h00c;
	localparam logic [AW-1:0] OFF_SIF   = 12'h010;
	localparam logic [AW-1:0] OFF_TEC   = 12'h014;
	localparam logic [AW-1:0] OFF_BUFC  = 12'h020;
	localparam logic [AW-1:0] OFF_BUFID = 12'h040;
	localparam logic [AW-1:0] BUF_MASK  = 12'hfe0;
	localparam int BIDX_LSB = 2;
	// -----------------------------------------------
	// Field positions
	// -----------------------------------------------
	localparam int F_ABORT_ALL = 12;
	localparam int F_CLK_SEL   = 11;
	localparam int F_PRESC     = 0;
	localparam int F_JUMP      = 6;
	localparam int F_PROP      = 0;
	localparam int F_PH1       = 3;
	localparam int F_SAM       = 6;
	localparam int F_PH2_FREE  = 7;
	localparam int F_PH2       = 8;
	localparam int F_ERR       = 5;
	localparam int F_WARN      = 10;
	localparam int F_PASSIVE   = 12;
	localparam int F_BUS_OFF   = 13;
	localparam int B_PRI       = 0;
	localparam int B_RTR       = 2;
	localparam int B_REQ       = 3;
	localparam int B_IE        = 4;
	localparam int B_ERR       = 5;
	localparam int B_ARB       = 6;
	localparam int B_ABT       = 7;
	// -----------------------------------------------
	// Counts, limits and response codes
	// -----------------------------------------------
	localparam logic [3:0] IDLE_BITS    = 4'hb;
	localparam logic [4:0] POS_ID_FIRST = 5'h01;
	localparam logic [4:0] POS_ID_LAST  = 5'h0b;
	localparam logic [4:0] POS_ACK      = 5'h0c;
	localparam logic [4:0] POS_LAST     = 5'h13;
	localparam logic [8:0] TEC_WARN     = 9'h060;
	localparam logic [8:0] TEC_PASSIVE  = 9'h07f;
	localparam logic [8:0] TEC_OFF      = 9'h0ff;
	localparam logic [8:0] TEC_MAX      = 9'h1ff;
	localparam logic [3:0] PH2_PROC     = 4'h2;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;
	typedef enum logic [2:0] {
		S_IDLE  = 3'b001,
		S_FRAME = 3'b010,
		S_OFF   = 3'b100
	} tx_state_t;
	typedef enum logic [3:0] {
		SEG_SYNC = 4'b0001,
		SEG_PROP = 4'b0010,
		SEG_PH1  = 4'b0100,
		SEG_PH2  = 4'b1000
	} seg_t;
endpackage : can_tx_pkg

// ---- can_tx_sched.sv ----
// CAN transmit scheduler with error counting and AXI4-Lite registers
`timescale 1ns/1ps
module can_tx_sched (
	// Clock, reset, enable
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	input  wire logic                     ce,
	// Module clock sources
	input  wire logic                     osc_tick,
	input  wire logic                     instr_tick,
	// CAN pins
	input  wire logic                     can_rx,
	output logic                          can_tx,
	// Receive side and recovery
	input  wire logic                     rtr_hit,
	input  wire logic [2:0]               rtr_buf,
	input  wire logic                     bus_recover,
	// Event outputs
	output logic                          send_irq,
	output logic                          error_irq,
	// AXI4-Lite write
	input  wire logic [can_tx_pkg::AW-1:0] awaddr,
	input  wire logic                     awvalid,
	output logic                          awready,
	input  wire logic [can_tx_pkg::DW-1:0] wdata,
	input  wire logic [3:0]               wstrb,
	input  wire logic                     wvalid,
	output logic                          wready,
	output logic [1:0]                    bresp,
	output logic                          bvalid,
	input  wire logic                     bready,
	// AXI4-Lite read
	input  wire logic [can_tx_pkg::AW-1:0] araddr,
	input  wire logic                     arvalid,
	output logic                          arready,
	output logic [can_tx_pkg::DW-1:0]      rdata,
	output logic [1:0]                    rresp,
	output logic                          rvalid,
	input  wire logic                     rready
);
	import can_tx_pkg::*;
	logic            abort_all_ff;
	logic            clk_sel_ff;
	logic [5:0]      presc_ff;
	logic [1:0]      jump_ff;
	logic [2:0]      prop_ff;
	logic [2:0]      ph1_ff;
	logic [2:0]      ph2_ff;
	logic            sam_ff;
	logic            ph2_free_ff;
	logic            err_flag_ff;
	logic            warn_ff;
	logic            passive_ff;
	logic            bus_off_ff;
	logic [NBUF-1:0] send_flag_ff;
	logic [NBUF-1:0] req_ff;
	logic [NBUF-1:0] ie_ff;
	logic [NBUF-1:0] rtr_en_ff;
	logic [NBUF-1:0] abt_ff;
	logic [NBUF-1:0] arb_ff;
	logic [NBUF-1:0] terr_ff;
	logic [NBUF-1:0] pend_ff;
	logic [1:0]      pri_ff [NBUF];
	logic [10:0]     ident_ff [NBUF];
	logic [8:0]      tec_ff;
	tx_state_t       st_ff;
	logic [3:0]      rec_cnt_ff;
	logic [4:0]      pos_ff;
	logic [2:0]      cur_ff;
	logic            wr_go;
	logic            rd_go;
	logic [2:0]      widx;
	logic [2:0]      ridx;
	logic            w_ctrl;
	logic            w_cfg1;
	logic            w_cfg2;
	logic            w_intf;
	logic            w_sif;
	logic            w_bufc;
	logic            w_bufid;
	logic            w_hit;
	logic            abort_kick;
	logic [DW-1:0]   rd_val;
	logic            rd_hit;
	logic            found;
	logic [2:0]      best;
	logic [1:0]      best_pri;
	logic            bus_idle;
	logic            smp;
	logic            in_id;
	logic            ev_arb;
	logic            ev_err;
	logic            ev_ok;
	logic            frame_bit;
	logic [3:0]      id_sel;
	logic [NBUF-1:0] one_hot_cur;
	logic            mclk_tick;
	bt_if            bt_c ();

	// -----------------------------------------------
	// Bit timer
	// -----------------------------------------------
	assign mclk_tick = clk_sel_ff ? instr_tick : osc_tick;
	assign bt_c.presc    = presc_ff;
	assign bt_c.jump     = jump_ff;
	assign bt_c.prop     = prop_ff;
	assign bt_c.ph1      = ph1_ff;
	assign bt_c.ph2      = ph2_ff;
	assign bt_c.ph2_free = ph2_free_ff;
	assign bt_c.triple_sample_select      = sam_ff;
	assign bt_c.idle     = bus_idle;
	can_bit_timer u_timer (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.ce        (ce),
		.mclk_tick (mclk_tick),
		.rx        (can_rx),
		.bt        (bt_c)
	);

	// -----------------------------------------------
	// Bus decode
	// -----------------------------------------------
	assign wr_go   = awvalid && awready && wvalid && wready;
	assign rd_go   = arvalid && arready;
	assign widx    = awaddr[BIDX_LSB +: 3];
	assign ridx    = araddr[BIDX_LSB +: 3];
	assign w_ctrl  = wr_go && awaddr == OFF_CTRL;
	assign w_cfg1  = wr_go && awaddr == OFF_CFG1;
	assign w_cfg2  = wr_go && awaddr == OFF_CFG2;
	assign w_intf  = wr_go && awaddr == OFF_INTF;
	assign w_sif   = wr_go && awaddr == OFF_SIF;
	assign w_bufc  = wr_go && (awaddr & BUF_MASK) == OFF_BUFC;
	assign w_bufid = wr_go && (awaddr & BUF_MASK) == OFF_BUFID;
	assign w_hit   = w_ctrl || w_cfg1 || w_cfg2 || w_intf || w_sif || w_bufc || w_bufid
		|| awaddr == OFF_TEC;
	assign abort_kick = w_ctrl && wstrb[1] && wdata[F_ABORT_ALL];

	always_comb begin
		rd_val = '0;
		rd_hit = 1'b1;
		if (araddr == OFF_CTRL) begin
			rd_val[F_ABORT_ALL] = abort_all_ff;
			rd_val[F_CLK_SEL]   = clk_sel_ff;
		end else if (araddr == OFF_CFG1) begin
			rd_val[F_PRESC +: 6] = presc_ff;
			rd_val[F_JUMP +: 2]  = jump_ff;
		end else if (araddr == OFF_CFG2) begin
			rd_val[F_PROP +: 3]  = prop_ff;
			rd_val[F_PH1 +: 3]   = ph1_ff;
			rd_val[F_SAM]        = sam_ff;
			rd_val[F_PH2_FREE]   = ph2_free_ff;
			rd_val[F_PH2 +: 3]   = ph2_ff;
		end else if (araddr == OFF_INTF) begin
			rd_val[F_ERR]     = err_flag_ff;
			rd_val[F_WARN]    = warn_ff;
			rd_val[F_PASSIVE] = passive_ff;
			rd_val[F_BUS_OFF] = bus_off_ff;
		end else if (araddr == OFF_SIF)
			rd_val[NBUF-1:0] = send_flag_ff;
		else if (araddr == OFF_TEC)
			rd_val[8:0] = tec_ff;
		else if ((araddr & BUF_MASK) == OFF_BUFC) begin
			rd_val[B_PRI +: 2] = pri_ff[ridx];
			rd_val[B_RTR]      = rtr_en_ff[ridx];
			rd_val[B_REQ]      = req_ff[ridx];
			rd_val[B_IE]       = ie_ff[ridx];
			rd_val[B_ERR]      = terr_ff[ridx];
			rd_val[B_ARB]      = arb_ff[ridx];
			rd_val[B_ABT]      = abt_ff[ridx];
		end else if ((araddr & BUF_MASK) == OFF_BUFID)
			rd_val[10:0] = ident_ff[ridx];
		else
			rd_hit = 1'b0;
	end

	// -----------------------------------------------
	// AXI4-Lite handshakes
	// -----------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end else if (ce) begin
			awready <= awvalid && wvalid && !awready && !bvalid;
			wready  <= awvalid && wvalid && !awready && !bvalid;
			if (wr_go) begin
				bvalid <= 1'b1;
				bresp  <= w_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bready)
				bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else if (ce) begin
			arready <= arvalid && !arready && !rvalid;
			if (rd_go) begin
				rvalid <= 1'b1;
				rdata  <= rd_val;
				rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (rready)
				rvalid <= 1'b0;
		end
	end

	// -----------------------------------------------
	// Configuration registers
	// -----------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			abort_all_ff <= 1'b0;
			clk_sel_ff   <= 1'b0;
			presc_ff     <= 6'h00;
			jump_ff      <= 2'h0;
			prop_ff      <= 3'h0;
			ph1_ff       <= 3'h0;
			sam_ff       <= 1'b0;
			ph2_free_ff  <= 1'b0;
			ph2_ff       <= 3'h0;
		end else if (ce) begin
			if (abort_kick)
				abort_all_ff <= 1'b1;
			else if (abort_all_ff && pend_ff == '0)
				abort_all_ff <= 1'b0;
			if (w_ctrl && wstrb[1])
				clk_sel_ff <= wdata[F_CLK_SEL];
			if (w_cfg1 && wstrb[0]) begin
				presc_ff <= wdata[F_PRESC +: 6];
				jump_ff  <= wdata[F_JUMP +: 2];
			end
			if (w_cfg2 && wstrb[0]) begin
				prop_ff     <= wdata[F_PROP +: 3];
				ph1_ff      <= wdata[F_PH1 +: 3];
				sam_ff      <= wdata[F_SAM];
				ph2_free_ff <= wdata[F_PH2_FREE];
			end
			if (w_cfg2 && wstrb[1])
				ph2_ff <= wdata[F_PH2 +: 3];
		end
	end

	// -----------------------------------------------
	// Buffer control and status
	// -----------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			req_ff    <= '0;
			ie_ff     <= '0;
			rtr_en_ff <= '0;
			abt_ff    <= '0;
			arb_ff    <= '0;
			terr_ff   <= '0;
			pend_ff   <= '0;
			for (int i = 0; i < NBUF; i++) begin
				pri_ff[i] <= 2'h0;
			end
		end else if (ce) begin
			for (int i = 0; i < NBUF; i++) begin
				if (w_bufc && wstrb[0] && widx == 3'(i)) begin
					pri_ff[i]    <= wdata[B_PRI +: 2];
					rtr_en_ff[i] <= wdata[B_RTR];
					ie_ff[i]     <= wdata[B_IE];
					if (wdata[B_REQ] && !req_ff[i]) begin
						req_ff[i]  <= 1'b1;
						abt_ff[i]  <= 1'b0;
						arb_ff[i]  <= 1'b0;
						terr_ff[i] <= 1'b0;
					end else if (!wdata[B_REQ] && req_ff[i]) begin
						if (st_ff == S_FRAME && cur_ff == 3'(i))
							pend_ff[i] <= 1'b1;
						else begin
							req_ff[i] <= 1'b0;
							abt_ff[i] <= 1'b1;
						end
					end
				end
				if (abort_kick && req_ff[i]) begin
					if (st_ff == S_FRAME && cur_ff == 3'(i))
						pend_ff[i] <= 1'b1;
					else begin
						req_ff[i] <= 1'b0;
						abt_ff[i] <= 1'b1;
					end
				end
				if (cur_ff == 3'(i) && ev_ok) begin
					req_ff[i]  <= 1'b0;
					pend_ff[i] <= 1'b0;
				end
				if (rtr_hit && rtr_en_ff[i] && rtr_buf == 3'(i) && st_ff != S_OFF) begin
					req_ff[i]  <= 1'b1;
					abt_ff[i]  <= 1'b0;
					arb_ff[i]  <= 1'b0;
					terr_ff[i] <= 1'b0;
				end
				if (cur_ff == 3'(i) && (ev_arb || ev_err)) begin
					arb_ff[i]  <= ev_arb ? 1'b1 : arb_ff[i];
					terr_ff[i] <= ev_err ? 1'b1 : terr_ff[i];
					if (pend_ff[i]) begin
						req_ff[i]  <= 1'b0;
						abt_ff[i]  <= 1'b1;
						pend_ff[i] <= 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NBUF; i++) begin
				ident_ff[i] <= 11'h000;
			end
		end else if (ce) begin
			for (int i = 0; i < NBUF; i++) begin
				if (w_bufid && widx == 3'(i) && wstrb[0])
					ident_ff[i][7:0] <= wdata[7:0];
				if (w_bufid && widx == 3'(i) && wstrb[1])
					ident_ff[i][10:8] <= wdata[10:8];
			end
		end
	end

	// -----------------------------------------------
	// Priority pick
	// -----------------------------------------------
	always_comb begin
		found    = 1'b0;
		best     = 3'h0;
		best_pri = 2'h0;
		for (int i = 0; i < NBUF; i++) begin
			if (req_ff[i] && !pend_ff[i] && (!found || pri_ff[i] >= best_pri)) begin
				found    = 1'b1;
				best     = 3'(i);
				best_pri = pri_ff[i];
			end
		end
	end

	// -----------------------------------------------
	// Frame engine
	// -----------------------------------------------
	assign bus_idle  = st_ff == S_IDLE && rec_cnt_ff == IDLE_BITS;
	assign smp       = bt_c.sample && st_ff == S_FRAME;
	assign in_id     = pos_ff >= POS_ID_FIRST && pos_ff <= POS_ID_LAST;
	assign id_sel    = 4'(POS_ID_LAST - pos_ff);
	assign frame_bit = in_id ? ident_ff[cur_ff][id_sel] : 1'b1;
	assign ev_arb = smp && in_id && can_tx && !bt_c.rx_bit;
	assign ev_err = smp && !ev_arb
		&& ((pos_ff == POS_ACK) ? bt_c.rx_bit : (can_tx != bt_c.rx_bit));
	assign ev_ok  = smp && !ev_arb && !ev_err && pos_ff == POS_LAST;
	assign one_hot_cur = {{(NBUF-1){1'b0}}, 1'b1} << cur_ff;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff      <= S_IDLE;
			rec_cnt_ff <= 4'h0;
			pos_ff     <= 5'h00;
			cur_ff     <= 3'h0;
			can_tx     <= 1'b1;
		end else if (ce) begin
			case (st_ff)
				S_IDLE: begin
					if (bt_c.sample)
						rec_cnt_ff <= !bt_c.rx_bit ? 4'h0 :
							(rec_cnt_ff == IDLE_BITS ? rec_cnt_ff : rec_cnt_ff + 4'h1);
					if (bt_c.bit_start && bus_idle && found && !abort_all_ff
						&& !abort_kick && !w_bufc) begin
						st_ff  <= S_FRAME;
						cur_ff <= best;
						pos_ff <= 5'h00;
						can_tx <= 1'b0;
					end
				end
				S_FRAME: begin
					if (ev_arb || ev_err || ev_ok) begin
						st_ff      <= S_IDLE;
						rec_cnt_ff <= 4'h0;
						can_tx     <= 1'b1;
					end else begin
						if (bt_c.sample)
							pos_ff <= pos_ff + 5'h01;
						if (bt_c.bit_start)
							can_tx <= frame_bit;
					end
				end
				S_OFF: begin
					can_tx     <= 1'b1;
					rec_cnt_ff <= 4'h0;
					if (bus_recover)
						st_ff <= S_IDLE;
				end
				default: st_ff <= S_IDLE;
			endcase
			if (st_ff != S_OFF && tec_ff > TEC_OFF) begin
				st_ff  <= S_OFF;
				can_tx <= 1'b1;
			end
		end
	end

	// -----------------------------------------------
	// Error counter and flags
	// -----------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst)
			tec_ff <= 9'h000;
		else if (ce) begin
			if (st_ff == S_OFF && bus_recover)
				tec_ff <= 9'h000;
			else if (ev_err && tec_ff != TEC_MAX)
				tec_ff <= tec_ff + 9'h001;
			else if (ev_ok && tec_ff != 9'h000)
				tec_ff <= tec_ff - 9'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			warn_ff      <= 1'b0;
			passive_ff   <= 1'b0;
			bus_off_ff   <= 1'b0;
			err_flag_ff  <= 1'b0;
			send_flag_ff <= '0;
			send_irq     <= 1'b0;
			error_irq    <= 1'b0;
		end else if (ce) begin
			warn_ff    <= tec_ff > TEC_WARN;
			passive_ff <= tec_ff > TEC_PASSIVE;
			bus_off_ff <= tec_ff > TEC_OFF;
			if ((tec_ff > TEC_WARN && !warn_ff) || (tec_ff > TEC_PASSIVE && !passive_ff)
				|| (tec_ff > TEC_OFF && !bus_off_ff))
				err_flag_ff <= 1'b1;
			else if (w_intf && wstrb[0] && wdata[F_ERR])
				err_flag_ff <= 1'b0;
			send_flag_ff <= (send_flag_ff & ~((w_sif && wstrb[0]) ? wdata[NBUF-1:0] : '0))
				| (ev_ok ? one_hot_cur : '0);
			send_irq  <= |(send_flag_ff & ie_ff);
			error_irq <= err_flag_ff;
		end
	end
endmodule : can_tx_sched

// ---- can_tx_sched_monitor.sv ----
// Port checker for the CAN transmit scheduler
`timescale 1ns/1ps
module can_tx_sched_monitor (
	input wire logic clk, sys_rst, can_tx, awready, wready, bvalid, bready,
	input wire logic arready, rvalid, rready, send_irq, error_irq,
	input wire logic [1:0] bresp,
	input wire logic [can_tx_pkg::DW-1:0] rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_aw_w_pair: assert property (awready |-> wready ##1 (!awready && !wready))
		else $error("ready split");
	a_b_follows: assert property ($rose(awready) |=> bvalid) else $error("no bvalid");
	a_b_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("b drop");
	a_b_once: assert property (bvalid && bready |=> !bvalid) else $error("b twice");
	a_r_follows: assert property ($rose(arready) |=> rvalid) else $error("no rvalid");
	a_r_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("r drop");
	a_reset_quiet: assert property ($fell(sys_rst) |-> can_tx && !send_irq && !error_irq)
		else $error("reset out");
	a_bit_length: assert property ($fell(can_tx) |=> !can_tx [*7]) else $error("short bit");
endmodule : can_tx_sched_monitor
bind can_tx_sched can_tx_sched_monitor u_mon (.clk, .sys_rst, .can_tx, .awready, .wready,
	.bvalid, .bready, .arready, .rvalid, .rready, .send_irq, .error_irq, .bresp, .rdata);

// ---- testbench.sv ----
// Bench for the CAN transmit scheduler against a behavioural model
`timescale 1ns/1ps
`define CK(n, e, s) begin n_checks++; if ((s) !== (e)) begin err_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench;
	import can_tx_pkg::*;
	logic clk = 0, sys_rst = 1, osc_tick = 0, jam = 1, ack_en = 1, rtr_hit = 0, bus_recover = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, can_rx, can_tx;
	logic awready, wready, bvalid, arready, rvalid, send_irq, error_irq;
	logic [2:0] rtr_buf = 3;
	logic [1:0] bresp, rresp;
	logic [AW-1:0] awaddr = 0, araddr = 0;
	logic [DW-1:0] wdata = 0, rdata, d;
	int err_count = 0, n_checks = 0, t, i, k, b, tec = 0, seed = 32'h8f8a3d1a, pri[8];
	can_tx_sched u_can_tx_sched (.*, .ce(1'b1), .instr_tick(1'b1), .wstrb(4'hf));
	can_node #(.BIT(16)) u_can_node (.*);
	initial forever #4 clk = ~clk;
	always @(posedge clk) osc_tick <= 1'($random(seed));
	task automatic report_and_stop();
		if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	task automatic stop_if(input logic c);
		if (c) begin err_count++; report_and_stop(); end
	endtask : stop_if
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v, input logic [1:0] r = 0);
		@(posedge clk);
		awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1; t = 0;
		do begin @(posedge clk); t++; if (awready) awvalid <= 0; if (wready) wvalid <= 0; end
		while (!bvalid && t < 99);
		bready <= 0;
		stop_if(t > 98);
		`CK("bresp", r, bresp)
	endtask : wr
	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e, m = '1,
		input logic [1:0] r = 0);
		@(posedge clk);
		araddr <= a; arvalid <= 1; rready <= 1; t = 0;
		do begin @(posedge clk); t++; if (arready) arvalid <= 0; end while (!rvalid && t < 99);
		rready <= 0;
		d = rdata;
		stop_if(t > 98);
		if (m) begin `CK("rresp", r, rresp) `CK("rdata", e, d & m) end
	endtask : rd
	task automatic poll(input logic [AW-1:0] a, input logic [DW-1:0] m, e);
		i = 0;
		do begin rd(a, 0, 0); i++; end while ((d & m) !== e && i < 400);
		`CK("poll", e, d & m)
		stop_if((d & m) !== e);
	endtask : poll
	// Model: best priority, ties to the highest index
	function automatic int pick();
		pick = -1;
		for (int j = 7; j >= 0; j--) if (pri[j] >= 0 && (pick < 0 || pri[j] > pri[pick])) pick = j;
	endfunction : pick
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 0;
		rd(OFF_TEC, 0);
		rd(12'h018, 0, '1, 2);
		wr(12'h01c, 1, 2);
		wr(OFF_CTRL, 'h800);
		wr(OFF_CFG2, 'h191);
		for (k = 0; k < 8; k++) begin
			pri[k] = $random(seed) & 3;
			wr(OFF_BUFC + 4 * k, 'h18 | pri[k]);
		end
		jam <= 0;
		for (k = 0; k < 8; k++) begin
			b = pick();
			poll(OFF_SIF, 'hff, 1 << b);
			`CK("send irq", 1'b1, send_irq)
			rd(OFF_BUFC + 4 * b, 'h10 | pri[b]);
			wr(OFF_SIF, 1 << b);
			pri[b] = -1;
		end
		wr(OFF_BUFC + 12, 'h14);
		rtr_hit <= 1;
		@(posedge clk) rtr_hit <= 0;
		poll(OFF_SIF, 'hff, 8);
		wr(OFF_SIF, 8);
		wr(OFF_BUFID, 'h7ff);
		wr(OFF_BUFC, 8);
		for (t = 0; t < 4000 && can_tx !== 1'b0; t++) @(posedge clk);
		stop_if(t > 3999);
		jam <= 1;
		poll(OFF_BUFC, 'hf8, 'h48);
		`CK("send irq", 1'b0, send_irq)
		wr(OFF_BUFC, 0);
		poll(OFF_BUFC, 'h88, 'h80);
		wr(OFF_CFG2, 'h51);
		rd(OFF_CFG2, 'h51);
		ack_en <= 0;
		jam <= 0;
		wr(OFF_BUFC, 8);
		rd(OFF_BUFC, 'h08);
		for (t = 0; t < 4000 && can_tx !== 1'b0; t++) @(posedge clk);
		stop_if(t > 3999);
		for (k = 0; k < 99 && can_tx === 1'b0; k++) @(posedge clk);
		`CK("bit clocks", 18, k)
		repeat (128) begin
			tec++;
			poll(OFF_TEC, 'h1ff, tec);
		end
		rd(OFF_BUFC, 'h28, 'hf8);
		rd(OFF_INTF, 'h1420, 'h3420);
		`CK("error irq", 1'b1, error_irq)
		wr(OFF_CTRL, 'h1800);
		poll(OFF_CTRL, 'h1000, 0);
		rd(OFF_BUFC, 'h80, 'h80);
		rd(OFF_SIF, 0);
		report_and_stop();
	end
endmodule : testbench
